//--- hw/lsirq_az_if.sv
// Interface between the register core and the auto-zero scheduler
`timescale 1ns/10ps
`default_nettype none
interface lsirq_az_if;
	logic [7:0] az_cfg;
	logic meas_cycle;
	logic first_cycle;
	logic az_run;
	logic start_prev;
	modport core (output az_cfg, meas_cycle, first_cycle, input az_run, start_prev);
	modport sched (input az_cfg, meas_cycle, first_cycle, output az_run, start_prev);
endinterface
`default_nettype wire

//--- hw/lsirq_az_sched.sv
// Auto-zero scheduler: decides which light cycles run offset search
`timescale 1ns/10ps
`default_nettype none
module lsirq_az_sched (
	// Clock and reset
	input wire logic mclk_in,
	input wire logic rst_b_in,
	// Link to register core
	lsirq_az_if.sched az
);
	typedef struct packed {
		logic [6:0] cnt;
		logic run;
	} lsirq_az_s;
	lsirq_az_s st_q, st_d;
	logic [6:0] n;
	// ****************************************
	// Interval counter
	// ****************************************
	always_comb begin
		n = az.az_cfg[lsirq_pkg::LSIRQ_AZ_N_MSB:0];
		st_d = st_q;
		st_d.run = 1'b0;
		if (az.meas_cycle) begin
			if (n == lsirq_pkg::LSIRQ_AZ_NEVER) begin // [R6]
				st_d.cnt = lsirq_pkg::LSIRQ_AZ_CNT_ONE;
			end else if (n == lsirq_pkg::LSIRQ_AZ_FIRST_ONLY) begin // [R6]
				st_d.run = az.first_cycle;
			end else if (az.first_cycle || st_q.cnt >= n) begin // [R6]
				st_d.run = 1'b1;
				st_d.cnt = lsirq_pkg::LSIRQ_AZ_CNT_ONE;
			end else begin
				st_d.cnt = 7'(st_q.cnt + lsirq_pkg::LSIRQ_AZ_CNT_ONE);
			end
		end
	end
	always_ff @(posedge mclk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			st_q <= '0;
		end else begin
			st_q <= st_d;
		end
	end
	assign az.az_run = st_q.run;
	// Mode 1 resumes from last offset, mode 0 restarts from zero
	assign az.start_prev = az.az_cfg[lsirq_pkg::LSIRQ_OFFSET_SEARCH_START_SELECT_BIT]; // [R5]
endmodule // lsirq_az_sched
`default_nettype wire

//--- hw/lsirq_core.sv
// Interrupt, sleep-after-interrupt and auto-zero configuration core
//
// Operation
// [R1] Clear-on-read set: any status read clears every flag.
// [R2] Oscillator off without power-on, or when sleep-after-irq and irq low.
// [R3] Host wakes device only by clearing pending flags; code also wakes it when the irq enable or sleep-after-irq bit is cleared.
// [R4] Sleep-after-irq changes no register; it only gates the oscillator.
// [R5] Search starts at zero in mode 0, previous offset in mode 1.
// [R6] Interval 0 never, 7Fh first cycle only, else every nth cycle.
// [R7] Saturation enable lets saturation flag pull the interrupt.
// [R8] Light enable lets light flag pull the interrupt.
// [R9] Status bits 7 and 4 set by events, cleared by writing one.
// [R10] Interrupt pin low while any enabled flag is set.
// [R11] Host writes zero to reserved configuration bits.
`timescale 1ns/10ps
`default_nettype none
module lsirq_core (
	// Clock and reset
	input wire logic mclk_in,
	input wire logic rst_b_in,
	// Register access port
	input wire logic [7:0] reg_addr_in,
	input wire logic reg_wr_in,
	input wire logic reg_rd_in,
	input wire logic [7:0] reg_wdata_in,
	output logic [7:0] reg_rdata_out,
	// Measurement engine events
	input wire logic sat_event_in,
	input wire logic light_event_in,
	input wire logic meas_cycle_in,
	input wire logic first_cycle_in,
	input wire logic power_on_bit_in,
	// Auto-zero controls
	output logic az_run_out,
	output logic offset_search_start_select_out,
	// Oscillator and interrupt pin
	output logic osc_en_out,
	output logic irq_pin_out,
	output logic irq_pin_oe_out
);
	typedef struct packed {
		logic [7:0] status;
		logic [7:0] sleep_cfg;
		logic [7:0] az_cfg;
		logic [7:0] irq_en;
		logic [7:0] rdata;
	} lsirq_core_s;
	lsirq_core_s st_q, st_d;
	lsirq_az_if az_link();
	logic [7:0] set_v;
	logic [7:0] clr_v;
	logic irq_active;

	function automatic logic hit(input logic [7:0] a, input logic [7:0] b);
		hit = (a == b);
	endfunction

	// ****************************************
	// Register update
	// ****************************************
	always_comb begin
		st_d = st_q;
		set_v = '0;
		clr_v = '0;
		set_v[lsirq_pkg::LSIRQ_SAT_BIT] = sat_event_in; // [R9]
		set_v[lsirq_pkg::LSIRQ_LIGHT_BIT] = light_event_in; // [R9]
		if (reg_wr_in && hit(reg_addr_in, lsirq_pkg::LSIRQ_STATUS_ADDR)) begin
			clr_v = reg_wdata_in & lsirq_pkg::LSIRQ_FLAG_MASK; // [R9]
		end
		if (reg_rd_in && hit(reg_addr_in, lsirq_pkg::LSIRQ_STATUS_ADDR)
			&& st_q.sleep_cfg[lsirq_pkg::LSIRQ_RD_CLR_BIT]) begin
			clr_v = lsirq_pkg::LSIRQ_FLAG_MASK; // [R1]
		end
		// Set beats clear so a same-cycle event is never lost
		st_d.status = ((st_q.status & ~clr_v) | set_v) & lsirq_pkg::LSIRQ_FLAG_MASK;
		if (reg_wr_in) begin
			case (reg_addr_in)
				lsirq_pkg::LSIRQ_SLEEP_CFG_ADDR: begin
					st_d.sleep_cfg = reg_wdata_in;
				end
				lsirq_pkg::LSIRQ_AZ_CFG_ADDR: begin
					st_d.az_cfg = reg_wdata_in;
				end
				lsirq_pkg::LSIRQ_IRQ_EN_ADDR: begin
					st_d.irq_en = reg_wdata_in;
				end
				default: begin
				end
			endcase
		end
		// Read data sampled before the clear-on-read takes effect
		case (reg_addr_in)
			lsirq_pkg::LSIRQ_STATUS_ADDR: st_d.rdata = st_q.status;
			lsirq_pkg::LSIRQ_SLEEP_CFG_ADDR: st_d.rdata = st_q.sleep_cfg;
			lsirq_pkg::LSIRQ_AZ_CFG_ADDR: st_d.rdata = st_q.az_cfg;
			lsirq_pkg::LSIRQ_IRQ_EN_ADDR: st_d.rdata = st_q.irq_en;
			default: st_d.rdata = '0;
		endcase
		if (!reg_rd_in) begin
			st_d.rdata = st_q.rdata;
		end
	end

	always_ff @(posedge mclk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			st_q.status <= lsirq_pkg::LSIRQ_STATUS_RST;
			st_q.sleep_cfg <= lsirq_pkg::LSIRQ_SLEEP_CFG_RST;
			st_q.az_cfg <= lsirq_pkg::LSIRQ_AZ_CFG_RST; // [R6]
			st_q.irq_en <= lsirq_pkg::LSIRQ_IRQ_EN_RST;
			st_q.rdata <= '0;
		end else begin
			st_q <= st_d;
		end
	end

	// ****************************************
	// Interrupt pin and oscillator gate
	// ****************************************
	assign irq_active = (st_q.status[lsirq_pkg::LSIRQ_SAT_BIT]
		&& st_q.irq_en[lsirq_pkg::LSIRQ_SAT_BIT]) // [R7]
		|| (st_q.status[lsirq_pkg::LSIRQ_LIGHT_BIT]
		&& st_q.irq_en[lsirq_pkg::LSIRQ_LIGHT_BIT]); // [R8]
	// Open drain: only ever drives low
	assign irq_pin_out = 1'b0;
	assign irq_pin_oe_out = irq_active; // [R10]
	// Gate only; sleep never touches a register, wake follows flag clear
	assign osc_en_out = power_on_bit_in
		&& !(st_q.sleep_cfg[lsirq_pkg::LSIRQ_SAI_BIT] && irq_active); // [R2] [R4] [R3]
	assign reg_rdata_out = st_q.rdata;

	// ****************************************
	// Auto-zero scheduling
	// ****************************************
	assign az_link.az_cfg = st_q.az_cfg;
	assign az_link.meas_cycle = meas_cycle_in;
	assign az_link.first_cycle = first_cycle_in;
	lsirq_az_sched u_az_sched (
		.mclk_in(mclk_in),
		.rst_b_in(rst_b_in),
		.az(az_link.sched)
	);
	assign az_run_out = az_link.az_run; // [R6]
	assign offset_search_start_select_out = az_link.start_prev; // [R5]
endmodule // lsirq_core
`default_nettype wire

//--- hw/lsirq_pkg.sv
// Package of constants for the light sensor interrupt and auto-zero block
package lsirq_pkg;
	// ****************************************
	// Register offsets
	// ****************************************
	localparam logic [7:0] LSIRQ_STATUS_ADDR = 8'h93;
	localparam logic [7:0] LSIRQ_SLEEP_CFG_ADDR = 8'hab;
	localparam logic [7:0] LSIRQ_AZ_CFG_ADDR = 8'hd6;
	localparam logic [7:0] LSIRQ_IRQ_EN_ADDR = 8'hdd;
	// ****************************************
	// Field positions
	// ****************************************
	localparam int LSIRQ_SAT_BIT = 7;
	localparam int LSIRQ_LIGHT_BIT = 4;
	localparam int LSIRQ_RD_CLR_BIT = 7;
	localparam int LSIRQ_SAI_BIT = 4;
	localparam int LSIRQ_OFFSET_SEARCH_START_SELECT_BIT = 7;
	localparam int LSIRQ_AZ_N_MSB = 6;
	// ****************************************
	// Reset values and masks
	// ****************************************
	localparam logic [7:0] LSIRQ_SLEEP_CFG_RST = 8'h00;
	localparam logic [7:0] LSIRQ_AZ_CFG_RST = 8'h7f;
	localparam logic [7:0] LSIRQ_IRQ_EN_RST = 8'h00;
	localparam logic [7:0] LSIRQ_STATUS_RST = 8'h00;
	localparam logic [7:0] LSIRQ_FLAG_MASK = 8'h90;
	localparam logic [6:0] LSIRQ_AZ_NEVER = 7'h00;
	localparam logic [6:0] LSIRQ_AZ_FIRST_ONLY = 7'h7f;
	localparam logic [6:0] LSIRQ_AZ_CNT_ONE = 7'h01;
endpackage

//--- sim/lsirq_core_monitor.sv
// Port checker for the interrupt and auto-zero core
`timescale 1ns/10ps
`default_nettype none
module lsirq_core_monitor (
	input wire logic mclk_in,
	input wire logic rst_b_in,
	input wire logic [7:0] reg_addr_in,
	input wire logic reg_wr_in,
	input wire logic reg_rd_in,
	input wire logic sat_event_in,
	input wire logic light_event_in,
	input wire logic meas_cycle_in,
	input wire logic power_on_bit_in,
	input wire logic [7:0] reg_rdata_out,
	input wire logic az_run_out,
	input wire logic offset_search_start_select_out,
	input wire logic osc_en_out,
	input wire logic irq_pin_out,
	input wire logic irq_pin_oe_out
);
	wire logic cause = sat_event_in | light_event_in | reg_wr_in;
	wire logic host = reg_wr_in | reg_rd_in;
	wire logic az_rd = reg_rd_in && reg_addr_in == lsirq_pkg::LSIRQ_AZ_CFG_ADDR;
	default clocking @(posedge mclk_in); endclocking
	default disable iff (!rst_b_in);
	a_osc_unpowered: assert property (!power_on_bit_in |-> !osc_en_out)
		else $error("osc on unpowered");
	a_osc_awake: assert property (power_on_bit_in && !irq_pin_oe_out |-> osc_en_out)
		else $error("osc off while idle");
	a_irq_rise: assert property ($rose(irq_pin_oe_out) |-> $past(cause))
		else $error("irq without cause");
	a_irq_fall: assert property ($fell(irq_pin_oe_out) |-> $past(host))
		else $error("irq released alone");
	a_irq_data_low: assert property (irq_pin_out == 1'b0)
		else $error("irq data high");
	a_az_after_meas: assert property (az_run_out |-> $past(meas_cycle_in))
		else $error("autozero without cycle");
	a_rdata_hold: assert property (!$past(reg_rd_in) |-> $stable(reg_rdata_out))
		else $error("read data moved");
	a_az_sel: assert property ($past(az_rd) |->
		reg_rdata_out[7] == offset_search_start_select_out)
		else $error("start select mismatch");
endmodule // lsirq_core_monitor
bind lsirq_core lsirq_core_monitor i_lsirq_core_monitor (.*);
`default_nettype wire

//--- sim/lsirq_core_tb.sv
// Self-checking bench for the interrupt and auto-zero core
`timescale 1ns/10ps
`default_nettype none
module lsirq_core_tb;
	localparam logic [7:0] ST = lsirq_pkg::LSIRQ_STATUS_ADDR;
	localparam logic [7:0] CF = lsirq_pkg::LSIRQ_SLEEP_CFG_ADDR;
	localparam logic [7:0] AZ = lsirq_pkg::LSIRQ_AZ_CFG_ADDR;
	localparam logic [7:0] EN = lsirq_pkg::LSIRQ_IRQ_EN_ADDR;
	logic mclk_in = 0, rst_b_in = 0, sat_event_in = 0, light_event_in = 0;
	logic meas_cycle_in = 0, first_cycle_in = 0, power_on_bit_in = 1;
	logic reg_wr_in, reg_rd_in, az_run_out, irq_pin_out, irq_pin_oe_out;
	logic offset_search_start_select_out, osc_en_out;
	logic [7:0] reg_addr_in, reg_wdata_in, reg_rdata_out, q, cnt;
	logic [6:0] n;
	logic [31:0] seed = 32'h24;
	int errors = 0, checks = 0, cyc = 0;
	lsirq_host i_lsirq_host (.mclk_in, .rdata_in(reg_rdata_out), .addr_out(reg_addr_in),
		.wdata_out(reg_wdata_in), .wr_out(reg_wr_in), .rd_out(reg_rd_in));
	lsirq_core i_lsirq_core (.*);
	initial forever #2.5 mclk_in = ~mclk_in;
	function automatic logic [7:0] runs(input logic [6:0] v);
		return (v == 7'h00) ? 8'h00 : (v == 7'h7f) ? 8'h01 : 8'h01 + 8'h0b / 8'(v);
	endfunction
	// Fixed seed keeps every run repeatable
	function automatic logic [31:0] xs(input logic [31:0] v);
		logic [31:0] t;
		t = v ^ (v << 13);
		t = t ^ (t >> 17);
		return t ^ (t << 5);
	endfunction
	task automatic chk(input string nm, input logic [7:0] s, e);
		checks++;
		if (s !== e) begin
			errors++;
			$display("[FAIL] %s expected %h seen %h", nm, e, s);
		end
	endtask
	task automatic w(input logic [7:0] a, d);
		i_lsirq_host.xfer(a, d, 1'b1, q);
	endtask
	task automatic r(input string nm, input logic [7:0] a, e);
		i_lsirq_host.xfer(a, 8'h00, 1'b0, q);
		chk(nm, q, e);
	endtask
	task automatic ev(input logic s, l);
		@(negedge mclk_in);
		sat_event_in = s;
		light_event_in = l;
		@(negedge mclk_in);
		sat_event_in = 0;
		light_event_in = 0;
	endtask
	task automatic tally_and_finish();
		$display("checks %0d errors %0d", checks, errors);
		if (errors == 0 && checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	always @(posedge mclk_in) begin
		cyc++;
		if (cyc == 2000) begin
			errors++;
			tally_and_finish();
		end
	end
	initial begin
		repeat (10) @(negedge mclk_in);
		rst_b_in = 1;
		r("cfg", CF, 8'h00);
		r("az", AZ, 8'h7f);
		r("en", EN, 8'h00);
		r("hole", 8'h92, 8'h00);
		$display("reset done");
		w(EN, 8'h90);
		ev(1, 0);
		chk("oe", 8'(irq_pin_oe_out), 8'h01);
		r("st", ST, 8'h80);
		w(ST, 8'h80);
		chk("oe", 8'(irq_pin_oe_out), 8'h00);
		ev(0, 1);
		chk("oe", 8'(irq_pin_oe_out), 8'h01);
		w(CF, 8'h10);
		chk("osc", 8'(osc_en_out), 8'h00);
		r("cfg", CF, 8'h10);
		w(ST, 8'h10);
		chk("osc", 8'(osc_en_out), 8'h01);
		power_on_bit_in = 0;
		#1;
		chk("osc", 8'(osc_en_out), 8'h00);
		power_on_bit_in = 1;
		$display("irq done");
		w(CF, 8'h80);
		w(EN, 8'h00);
		ev(1, 1);
		chk("oe", 8'(irq_pin_oe_out), 8'h00);
		r("st", ST, 8'h90);
		r("st", ST, 8'h00);
		// Only a status read may clear
		ev(1, 0);
		r("cfg", CF, 8'h80);
		r("st", ST, 8'h80);
		// Event on the clearing read edge must survive
		fork
			i_lsirq_host.xfer(ST, 8'h00, 1'b0, q);
			ev(1, 0);
		join
		chk("st", q, 8'h00);
		r("st", ST, 8'h80);
		ev(0, 1);
		w(ST, 8'h6f);
		r("st", ST, 8'h10);
		r("st", ST, 8'h00);
		$display("clear done");
		w(AZ, 8'h80);
		chk("sel", 8'(offset_search_start_select_out), 8'h01);
		for (int i = 0; i < 6; i++) begin
			seed = xs(seed);
			n = (i == 0) ? 7'h00 : (i == 1) ? 7'h7f : 7'(seed % 12 + 1);
			w(AZ, {1'b0, n});
			cnt = 0;
			for (int k = 0; k < 12; k++) begin
				@(negedge mclk_in);
				meas_cycle_in = 1;
				first_cycle_in = (k == 0);
				@(negedge mclk_in);
				meas_cycle_in = 0;
				first_cycle_in = 0;
				cnt += 8'(az_run_out);
			end
			chk("runs", cnt, runs(n));
		end
		chk("sel", 8'(offset_search_start_select_out), 8'h00);
		$display("autozero done");
		tally_and_finish();
	end
endmodule // lsirq_core_tb
`default_nettype wire

//--- sim/lsirq_host.sv
// Host model driving the register port
`timescale 1ns/10ps
`default_nettype none
module lsirq_host (
	input wire logic mclk_in,
	input wire logic [7:0] rdata_in,
	output logic [7:0] addr_out,
	output logic [7:0] wdata_out,
	output logic wr_out,
	output logic rd_out
);
	initial {addr_out, wdata_out, wr_out, rd_out} = '0;
	// Flags only cleared by host access; address and data inverted on release, strobes driven low
	task automatic xfer(input logic [7:0] a, d, input logic w, output logic [7:0] q);
		@(negedge mclk_in);
		addr_out = a;
		wdata_out = d;
		wr_out = w;
		rd_out = !w;
		@(negedge mclk_in);
		wr_out = 1'b0;
		rd_out = 1'b0;
		q = rdata_in;
		addr_out = ~a;
		wdata_out = ~d;
	endtask
endmodule // lsirq_host
`default_nettype wire
